// [logic/msms_pkg.sv]
// ****************************************************************
// Shared constants and types of the move sequencer.
// ****************************************************************
package msms_pkg;

  // Transfer operations accepted on the issue port.
  typedef enum logic [1:0] {
    OP_LOAD_MULTIPLE = 2'h0,
    OP_STORE_MULTIPLE = 2'h1,
    OP_LOAD_STRING_IMM = 2'h2,
    OP_LOAD_STRING_IDX = 2'h3
  } msms_op_type;

  // Sequencer states, one-hot.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_FIN = 3'b100
  } msms_state_type;

  localparam int MSMS_DATA_W = 32;
  localparam int MSMS_IDX_W = 5;
  localparam int MSMS_CNT_W = 8;
  localparam int MSMS_DISP_W = 16;
  localparam int MSMS_PAGE_LSB = 12;
  localparam int MSMS_XER_CNT_HI = 6;
  localparam int MSMS_FIFO_DEPTH = 4;
  localparam int MSMS_RSP_W = 33;
  localparam int MSMS_FAULT_BIT = 32;
  localparam logic [MSMS_CNT_W-1:0] MSMS_REG_LIMIT = 8'h20;
  localparam logic [MSMS_CNT_W-1:0] MSMS_IMM_ZERO_COUNT = 8'h20;
  localparam logic [MSMS_DATA_W-1:0] MSMS_WORD_STEP = 32'h00000004;
  localparam logic [MSMS_DATA_W-1:0] MSMS_BYTE_STEP = 32'h00000001;
  localparam logic [1:0] MSMS_LAST_LANE = 2'h3;
  localparam logic [MSMS_DATA_W-1:0] MSMS_ACC_RESET = 32'h00000000;

endpackage

// [logic/msms_stream_if.sv]
`timescale 1ns/1ps
// ****************************************************************
// Valid/ready word stream between sequencer and its FIFO.
// ****************************************************************
interface msms_stream_if #(
  parameter int WIDTH = 33
);
  logic [WIDTH-1:0] data;
  logic valid;
  logic ready;

  modport src(output data, output valid, input ready);
  modport snk(input data, input valid, output ready);
endinterface

// [logic/msms_fifo.sv]
`timescale 1ns/1ps
// ****************************************************************
// Small synchronous FIFO with valid/ready on both sides.
// ****************************************************************
module msms_fifo #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 4
) (
  input wire logic clk_sys,
  input wire logic rst,
  msms_stream_if.snk inSide,
  msms_stream_if.src outSide
);
  import msms_pkg::*;

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [AW-1:0] LAST_SLOT = AW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
  } msms_fifo_state_type;

  msms_fifo_state_type s_reg;
  msms_fifo_state_type s_next;
  logic pushFire;
  logic popFire;

  // Honest flags: ready drops at full, valid drops at empty.
  assign inSide.ready = (s_reg.cnt != FULL_CNT);
  assign outSide.valid = (s_reg.cnt != '0);
  assign outSide.data = s_reg.mem[s_reg.rp];
  assign pushFire = inSide.valid && inSide.ready;
  assign popFire = outSide.valid && outSide.ready;

  // Pointer and occupancy update.
  always_comb begin
    s_next = s_reg;
    if (pushFire) begin
      s_next.mem[s_reg.wp] = inSide.data;
      s_next.wp = (s_reg.wp == LAST_SLOT) ? '0 : s_reg.wp + 1'b1;
    end
    if (popFire) begin
      s_next.rp = (s_reg.rp == LAST_SLOT) ? '0 : s_reg.rp + 1'b1;
    end
    if (pushFire && !popFire) begin
      s_next.cnt = s_reg.cnt + 1'b1;
    end else if (popFire && !pushFire) begin
      s_next.cnt = s_reg.cnt - 1'b1;
    end
  end

  // State register.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule

// [logic/msms_sequencer.sv]
`timescale 1ns/1ps
// ****************************************************************
// Load/store multiple and load string sequencer.
// ****************************************************************
// How it works
// - Page fault: finish first page, skip second
// - Load multiple skips writing in-range base register
// - Base field zero: register zero loaded normally
// - Misaligned multiple within one page executes, not rejected
// - Load multiple: EA, 32 minus index words
// - Store multiple: EA, 32 minus index words
// - Misaligned page-crossing multiple raises alignment exception
// - Zero-count indexed string: no access, no change
// - Immediate string: base address, count zero means 32
// - Bytes fill left to right, registers wrap
// - Partial last register gets zeroed low bytes
// - String load skips in-range base register
// - String base field zero: register zero loaded
// - Indexed string: base plus index, count field
// - Registers equal count over four rounded up
module msms_sequencer #(
  parameter int FIFO_DEPTH = msms_pkg::MSMS_FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic cmdValid,
  output logic cmdReady,
  input wire msms_pkg::msms_op_type cmdOp,
  input wire logic [msms_pkg::MSMS_IDX_W-1:0] cmdRegIdx,
  input wire logic [msms_pkg::MSMS_IDX_W-1:0] cmdBaseField,
  input wire logic [msms_pkg::MSMS_DATA_W-1:0] cmdBaseValue,
  input wire logic [msms_pkg::MSMS_DATA_W-1:0] cmdIndexValue,
  input wire logic [msms_pkg::MSMS_DISP_W-1:0] cmdDisp,
  input wire logic [msms_pkg::MSMS_IDX_W-1:0] cmdImmByteCount,
  input wire logic [msms_pkg::MSMS_DATA_W-1:0] integerExceptionReg,
  output logic [msms_pkg::MSMS_IDX_W-1:0] gprRdIdx,
  input wire logic [msms_pkg::MSMS_DATA_W-1:0] gprRdData,
  output logic gprWrValid,
  input wire logic gprWrReady,
  output logic [msms_pkg::MSMS_IDX_W-1:0] gprWrIdx,
  output logic [msms_pkg::MSMS_DATA_W-1:0] gprWrData,
  output logic memReqValid,
  input wire logic memReqReady,
  output logic memReqWrite,
  output logic memReqByte,
  output logic [msms_pkg::MSMS_DATA_W-1:0] memReqAddr,
  output logic [msms_pkg::MSMS_DATA_W-1:0] memReqData,
  input wire logic memRspValid,
  output logic memRspReady,
  input wire logic [msms_pkg::MSMS_DATA_W-1:0] memRspData,
  input wire logic memRspFault,
  output logic doneValid,
  output logic doneDataExc,
  output logic doneAlignExc
);
  import msms_pkg::*;

  // ****************************************************************
  // State and decode helpers.
  // ****************************************************************

  typedef struct packed {
    msms_state_type st;
    msms_op_type op;
    logic [MSMS_IDX_W-1:0] baseIdx;
    logic baseUsed;
    logic [MSMS_DATA_W-1:0] addr;
    logic [MSMS_DATA_W-1:0] prevAddr;
    logic firstReq;
    logic probe;
    logic [MSMS_CNT_W-1:0] reqLeft;
    logic [MSMS_CNT_W-1:0] rspLeft;
    logic [MSMS_CNT_W-1:0] outCnt;
    logic [MSMS_IDX_W-1:0] issueIdx;
    logic [MSMS_IDX_W-1:0] drainIdx;
    logic [1:0] lane;
    logic [MSMS_DATA_W-1:0] acc;
    logic fault;
    logic wrValid;
    logic [MSMS_IDX_W-1:0] wrIdx;
    logic [MSMS_DATA_W-1:0] wrData;
    logic doneValid;
    logic doneDataExc;
    logic doneAlignExc;
  } msms_seq_state_type;

  // True for every operation that fills registers from memory.
  function automatic logic msmsIsLoad(input msms_op_type op);
    msmsIsLoad = (op != OP_STORE_MULTIPLE);
  endfunction

  // True for the byte-granular string operations.
  function automatic logic msmsIsString(input msms_op_type op);
    msmsIsString = (op == OP_LOAD_STRING_IMM) || (op == OP_LOAD_STRING_IDX);
  endfunction

  // Page number of an effective address.
  function automatic logic [MSMS_DATA_W-MSMS_PAGE_LSB-1:0] msmsPage(
    input logic [MSMS_DATA_W-1:0] a
  );
    msmsPage = a[MSMS_DATA_W-1:MSMS_PAGE_LSB];
  endfunction

  msms_seq_state_type s_reg;
  msms_seq_state_type s_next;

  msms_stream_if #(.WIDTH(MSMS_RSP_W)) rspIn ();
  msms_stream_if #(.WIDTH(MSMS_RSP_W)) rspOut ();

  logic [MSMS_DATA_W-1:0] baseSrc;
  logic [MSMS_DATA_W-1:0] eaStart;
  logic [MSMS_DATA_W-1:0] eaLast;
  logic [MSMS_CNT_W-1:0] wordCount;
  logic [MSMS_CNT_W-1:0] byteCount;
  logic newPage;
  logic issueOk;
  logic reqFire;
  logic drainReady;
  logic drainFire;
  logic skipWrite;

  // ****************************************************************
  // Response FIFO between memory path and register writer.
  // ****************************************************************

  // Memory answers enter the FIFO with their fault flag on top.
  assign rspIn.valid = memRspValid;
  assign rspIn.data = {memRspFault, memRspData};
  assign memRspReady = rspIn.ready;

  msms_fifo #(
    .WIDTH(MSMS_RSP_W),
    .DEPTH(FIFO_DEPTH)
  ) rspFifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .inSide(rspIn),
    .outSide(rspOut)
  );

  // The writer stalls the FIFO while a register write is unaccepted.
  assign drainReady = !s_reg.wrValid || gprWrReady;
  assign rspOut.ready = drainReady;
  assign drainFire = rspOut.valid && drainReady;

  // ****************************************************************
  // Command decode at issue time.
  // ****************************************************************

  // A zero base field means a zero address operand, not register zero.
  assign baseSrc = (cmdBaseField == '0) ? '0 : cmdBaseValue;

  // Effective address and transfer length per operation.
  always_comb begin
    eaStart = baseSrc;
    wordCount = MSMS_REG_LIMIT - {3'b000, cmdRegIdx};
    byteCount = {3'b000, cmdImmByteCount};
    case (cmdOp)
      OP_LOAD_MULTIPLE, OP_STORE_MULTIPLE: begin
        eaStart = baseSrc + {{(MSMS_DATA_W-MSMS_DISP_W){cmdDisp[MSMS_DISP_W-1]}}, cmdDisp};
      end
      OP_LOAD_STRING_IMM: begin
        if (cmdImmByteCount == '0) begin
          byteCount = MSMS_IMM_ZERO_COUNT;
        end
      end
      OP_LOAD_STRING_IDX: begin
        eaStart = baseSrc + cmdIndexValue;
        byteCount = {1'b0, integerExceptionReg[MSMS_XER_CNT_HI:0]};
      end
      default: begin
        eaStart = baseSrc;
      end
    endcase
    eaLast = eaStart + {22'h0, wordCount, 2'b00} - MSMS_BYTE_STEP;
  end

  // ****************************************************************
  // Memory request issue.
  // ****************************************************************

  // The first access of each page is a probe that must answer alone.
  assign newPage = s_reg.firstReq || (msmsPage(s_reg.addr) != msmsPage(s_reg.prevAddr));
  assign issueOk = (s_reg.st == ST_RUN) && (s_reg.reqLeft != '0) && !s_reg.fault &&
    ((s_reg.outCnt == '0) || (!newPage && !s_reg.probe));
  assign reqFire = issueOk && memReqReady;

  // Requests go out in ascending order from the tracked address.
  assign memReqValid = issueOk;
  assign memReqAddr = s_reg.addr;
  assign memReqWrite = (s_reg.op == OP_STORE_MULTIPLE);
  assign memReqByte = msmsIsString(s_reg.op);
  assign gprRdIdx = s_reg.issueIdx;
  assign memReqData = gprRdData;

  // Base register in range is protected when it is a real address source.
  assign skipWrite = s_reg.baseUsed && (s_reg.drainIdx == s_reg.baseIdx);

  // ****************************************************************
  // Sequencer next state.
  // ****************************************************************

  always_comb begin
    logic [MSMS_DATA_W-1:0] accNew;
    logic [MSMS_RSP_W-1:0] rsp;
    accNew = s_reg.acc;
    rsp = rspOut.data;
    s_next = s_reg;
    s_next.doneValid = 1'b0;
    s_next.doneDataExc = 1'b0;
    s_next.doneAlignExc = 1'b0;

    // A pending register write leaves once the file accepts it.
    if (s_reg.wrValid && gprWrReady) begin
      s_next.wrValid = 1'b0;
    end

    case (s_reg.st)
      ST_IDLE: begin
        if (cmdValid) begin
          s_next.op = cmdOp;
          s_next.baseIdx = cmdBaseField;
          s_next.baseUsed = (cmdBaseField != '0);
          s_next.addr = eaStart;
          s_next.prevAddr = eaStart;
          s_next.firstReq = 1'b1;
          s_next.probe = 1'b0;
          s_next.outCnt = '0;
          s_next.issueIdx = cmdRegIdx;
          s_next.drainIdx = cmdRegIdx;
          s_next.lane = '0;
          s_next.acc = MSMS_ACC_RESET;
          s_next.fault = 1'b0;
          s_next.st = ST_RUN;
          if (msmsIsString(cmdOp)) begin
            s_next.reqLeft = byteCount;
            s_next.rspLeft = byteCount;
          end else begin
            s_next.reqLeft = wordCount;
            s_next.rspLeft = wordCount;
          end
          if (!msmsIsString(cmdOp) && (eaStart[1:0] != 2'b00) &&
              (msmsPage(eaStart) != msmsPage(eaLast))) begin
            // Misaligned and crossing a page: hand over to the handler.
            s_next.st = ST_FIN;
            s_next.doneValid = 1'b1;
            s_next.doneAlignExc = 1'b1;
          end else if (msmsIsString(cmdOp) && (byteCount == '0)) begin
            // Zero-length string: finish without touching anything.
            s_next.st = ST_FIN;
            s_next.doneValid = 1'b1;
          end
        end
      end

      ST_RUN: begin
        // Advance the request side by a word or a byte.
        if (reqFire) begin
          s_next.prevAddr = s_reg.addr;
          s_next.addr = s_reg.addr + (msmsIsString(s_reg.op) ? MSMS_BYTE_STEP :
            MSMS_WORD_STEP);
          s_next.firstReq = 1'b0;
          s_next.reqLeft = s_reg.reqLeft - 1'b1;
          s_next.issueIdx = s_reg.issueIdx + 1'b1;
        end

        // A page probe stays alone until its answer is drained.
        if (reqFire && newPage) begin
          s_next.probe = 1'b1;
        end else if (s_reg.outCnt == '0) begin
          s_next.probe = 1'b0;
        end

        // Outstanding count follows issued minus drained answers.
        if (reqFire && !drainFire) begin
          s_next.outCnt = s_reg.outCnt + 1'b1;
        end else if (drainFire && !reqFire) begin
          s_next.outCnt = s_reg.outCnt - 1'b1;
        end

        // Drain one answer into the register writer.
        if (drainFire) begin
          if (rsp[MSMS_FAULT_BIT] || s_reg.fault) begin
            s_next.fault = 1'b1;
          end else if (msmsIsLoad(s_reg.op)) begin
            s_next.rspLeft = s_reg.rspLeft - 1'b1;
            if (!msmsIsString(s_reg.op)) begin
              s_next.wrValid = !skipWrite;
              s_next.wrIdx = s_reg.drainIdx;
              s_next.wrData = rsp[MSMS_DATA_W-1:0];
              s_next.drainIdx = s_reg.drainIdx + 1'b1;
            end else begin
              // Bytes land from the most significant lane downward.
              accNew[{~s_reg.lane, 3'b000} +: 8] = rsp[7:0];
              if ((s_reg.lane == MSMS_LAST_LANE) || (s_reg.rspLeft == 8'h01)) begin
                // Accumulator starts cleared, so unfilled low bytes are zero.
                s_next.wrValid = !skipWrite;
                s_next.wrIdx = s_reg.drainIdx;
                s_next.wrData = accNew;
                s_next.acc = MSMS_ACC_RESET;
                s_next.lane = '0;
                s_next.drainIdx = s_reg.drainIdx + 1'b1;
              end else begin
                s_next.acc = accNew;
                s_next.lane = s_reg.lane + 1'b1;
              end
            end
          end
        end

        // Finish once every answer is drained and the write has left.
        if ((s_reg.outCnt == '0) && !rspOut.valid && !s_reg.wrValid &&
            ((s_reg.reqLeft == '0) || s_reg.fault)) begin
          s_next.st = ST_FIN;
          s_next.doneValid = 1'b1;
          s_next.doneDataExc = s_reg.fault;
        end
      end

      ST_FIN: begin
        s_next.st = ST_IDLE;
      end

      default: begin
        s_next.st = ST_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // State register and outputs.
  // ****************************************************************

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.st <= ST_IDLE;
      s_reg.op <= OP_LOAD_MULTIPLE;
      s_reg.acc <= MSMS_ACC_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // Handshake and completion outputs.
  assign cmdReady = (s_reg.st == ST_IDLE);
  assign gprWrValid = s_reg.wrValid;
  assign gprWrIdx = s_reg.wrIdx;
  assign gprWrData = s_reg.wrData;
  assign doneValid = s_reg.doneValid;
  assign doneDataExc = s_reg.doneDataExc;
  assign doneAlignExc = s_reg.doneAlignExc;
endmodule

// [verification/msms_sequencer_chk.sv]
`timescale 1ns/1ps
// ****************************************************************
// Port checks of the move sequencer.
// ****************************************************************
module msms_sequencer_chk (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic cmdValid,
  input wire logic cmdReady,
  input wire msms_pkg::msms_op_type cmdOp,
  input wire logic [4:0] cmdBaseField,
  input wire logic [31:0] integerExceptionReg,
  input wire logic gprWrValid,
  input wire logic gprWrReady,
  input wire logic [4:0] gprWrIdx,
  input wire logic [31:0] gprWrData,
  input wire logic memReqValid,
  input wire logic memReqReady,
  input wire logic memReqByte,
  input wire logic memReqWrite,
  input wire logic [31:0] memReqAddr,
  input wire logic memRspValid,
  input wire logic memRspReady,
  input wire logic memRspFault,
  input wire logic doneValid,
  input wire logic doneAlignExc
);
  import msms_pkg::*;
  msms_op_type opCode_reg;
  logic [4:0] baseField_reg;
  logic [31:0] lastAddr_reg;
  logic haveLast_reg;
  logic faultSeen_reg;
  wire take = cmdValid && cmdReady;
  // Taken command, last accepted address and whether a fault came back.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      opCode_reg <= OP_LOAD_MULTIPLE;
      baseField_reg <= 5'h0;
      lastAddr_reg <= 32'h0;
      haveLast_reg <= 1'h0;
      faultSeen_reg <= 1'h0;
    end else begin
      if (take) begin
        opCode_reg <= cmdOp;
        baseField_reg <= cmdBaseField;
        haveLast_reg <= 1'h0;
        faultSeen_reg <= 1'h0;
      end
      if (memReqValid && memReqReady) begin
        lastAddr_reg <= memReqAddr;
        haveLast_reg <= 1'h1;
      end
      if (memRspValid && memRspReady && memRspFault) begin
        faultSeen_reg <= 1'h1;
      end
    end
  end
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  a_take_busy: assert property (
    take |=> !cmdReady) else $error("Ready stayed high after a take.");
  a_zero_count: assert property (
    take && cmdOp == OP_LOAD_STRING_IDX && integerExceptionReg[6:0] == 7'h0
    |=> doneValid && !memReqValid && !gprWrValid) else $error("Empty string not quick.");
  a_req_hold: assert property (
    memReqValid && !memReqReady |=> memReqValid && $stable(memReqAddr) && $stable(memReqByte))
    else $error("Request changed while waiting.");
  a_addr_ascend: assert property (
    memReqValid && memReqReady && haveLast_reg
    |-> memReqAddr == lastAddr_reg + (memReqByte ? MSMS_BYTE_STEP : MSMS_WORD_STEP))
    else $error("Address did not step up.");
  a_access_kind: assert property (
    memReqValid |-> memReqWrite == (opCode_reg == OP_STORE_MULTIPLE)
    && memReqByte == opCode_reg[1]) else $error("Wrong access kind.");
  a_skip_base: assert property (
    gprWrValid && baseField_reg != 5'h0 && opCode_reg != OP_STORE_MULTIPLE
    |-> gprWrIdx != baseField_reg) else $error("Base register written.");
  a_wr_hold: assert property (
    gprWrValid && !gprWrReady |=> gprWrValid && $stable(gprWrIdx) && $stable(gprWrData))
    else $error("Register write changed while waiting.");
  a_fault_stop: assert property (
    faultSeen_reg |-> !memReqValid) else $error("Request after a fault.");
  a_align_quick: assert property (
    doneAlignExc |-> doneValid && $past(take)) else $error("Alignment end not quick.");
  a_done_pulse: assert property (
    doneValid |-> !cmdReady ##1 !doneValid) else $error("Done not a single pulse.");
endmodule

// [verification/msms_mem_model.sv]
`timescale 1ns/1ps
// ****************************************************************
// Data memory path model with in-order answers and one faulting page.
// ****************************************************************
module msms_mem_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic slow,
  input wire logic [19:0] faultPage,
  input wire logic memReqValid,
  output logic memReqReady,
  input wire logic memReqByte,
  input wire logic [31:0] memReqAddr,
  output logic memRspValid,
  input wire logic memRspReady,
  output logic [31:0] memRspData,
  output logic memRspFault
);
  logic [32:0] pend[$];
  int gap;
  logic ok;
  // Content of one byte of memory.
  function automatic logic [7:0] mb(input logic [31:0] a);
    return a[7:0] ^ a[15:8];
  endfunction
  // Queues answers in order and shows the oldest; idle data is inverted.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pend.delete();
      gap = 0;
      memReqReady <= 1'h1;
      memRspValid <= 1'h0;
      {memRspFault, memRspData} <= 33'h0;
    end else begin
      if (memRspValid && memRspReady) begin
        void'(pend.pop_front());
      end
      if (gap != 0) begin
        gap = gap - 1;
      end
      if (memReqValid && memReqReady) begin
        pend.push_back({memReqAddr[31:12] == faultPage, memReqByte ? {24'h0, mb(memReqAddr)} :
          {mb(memReqAddr), mb(memReqAddr + 32'h1), mb(memReqAddr + 32'h2),
          mb(memReqAddr + 32'h3)}});
        gap = slow ? 3 : 0;
      end
      ok = pend.size() != 0 && gap == 0;
      memReqReady <= gap == 0;
      memRspValid <= ok;
      {memRspFault, memRspData} <= ok ? pend[0] : {1'h0, ~memRspData};
    end
  end
endmodule

// [verification/tb.sv]
`timescale 1ns/1ps
`define CHK(g, e) \
  begin \
    num_checks++; \
    if ((g) !== (e)) begin \
      bad_count++; \
      $display("ERROR at %0t: got %h, expected %h", $time, g, e); \
    end \
  end
// ****************************************************************
// Self-checking bench of the move sequencer.
// ****************************************************************
module tb;
  import msms_pkg::*;
  typedef struct {
    msms_op_type op;
    logic [4:0] rd;
    logic [4:0] bf;
    logic [31:0] bv;
    logic [31:0] off;
    logic [6:0] n;
    int mode;
  } msms_row_type;
  logic clk_sys = 1'h0;
  logic rst = 1'h1;
  logic cmdValid = 1'h0;
  msms_op_type cmdOp = OP_LOAD_MULTIPLE;
  logic [4:0] cmdRegIdx = 5'h0, cmdBaseField = 5'h0, cmdImmByteCount = 5'h0, gprRdIdx, gprWrIdx;
  logic [31:0] cmdBaseValue = 32'h0, cmdIndexValue = 32'h0, integerExceptionReg = 32'h0;
  logic [15:0] cmdDisp = 16'h0;
  logic [31:0] gprRdData, gprWrData, memReqAddr, memReqData, memRspData;
  logic gprWrReady = 1'h1, slowMem = 1'h0, expD, expA, sawFull;
  logic cmdReady, gprWrValid, memReqValid, memReqReady, memReqWrite, memReqByte;
  logic memRspValid, memRspReady, memRspFault, doneValid, doneDataExc, doneAlignExc;
  logic [19:0] faultPage = 20'hfffff;
  logic [36:0] expW[$], gotW[$];
  logic [65:0] expR[$], gotR[$];
  int bad_count = 0, num_checks = 0, cyc = 0, base = 0, stallMode = 0;
  msms_row_type rows [9] = '{
    '{OP_LOAD_MULTIPLE, 5'h1d, 5'h03, 32'h100, 32'h10, 7'h0, 0},
    '{OP_STORE_MULTIPLE, 5'h1e, 5'h00, 32'hdead0000, 32'h200, 7'h0, 1},
    '{OP_LOAD_MULTIPLE, 5'h1e, 5'h1f, 32'h300, 32'hfff0, 7'h0, 1},
    '{OP_LOAD_MULTIPLE, 5'h00, 5'h00, 32'h0, 32'h400, 7'h0, 2},
    '{OP_LOAD_MULTIPLE, 5'h1e, 5'h05, 32'h102, 32'h0, 7'h0, 0},
    '{OP_LOAD_STRING_IMM, 5'h1f, 5'h00, 32'h77, 32'h0, 7'h6, 0},
    '{OP_LOAD_STRING_IMM, 5'h18, 5'h1a, 32'h500, 32'h0, 7'h0, 1},
    '{OP_LOAD_STRING_IDX, 5'h05, 5'h02, 32'h600, 32'h20, 7'h5, 0},
    '{OP_LOAD_STRING_IDX, 5'h07, 5'h02, 32'h600, 32'h0, 7'h0, 0}};
  msms_sequencer uut (.*);
  msms_mem_model mem (.clk_sys, .rst, .slow(slowMem), .faultPage, .memReqValid, .memReqReady,
    .memReqByte, .memReqAddr, .memRspValid, .memRspReady, .memRspData, .memRspFault);
  // Register file contents are a pattern of the index.
  assign gprRdData = {27'h3a5c0de, gprRdIdx};
  // Clock.
  always #2.5 clk_sys = ~clk_sys;
  // Register file readiness: always, every other cycle, or a long stall.
  always @(negedge clk_sys) begin
    cyc <= cyc + 1;
    gprWrReady <= stallMode == 0 || (stallMode == 1 ? cyc[0] : (cyc - base < 6 || cyc - base > 40));
  end
  // Logs accepted writes and requests; notes a full answer buffer.
  always @(posedge clk_sys) begin
    if (!rst) begin
      if (gprWrValid && gprWrReady) gotW.push_back({gprWrIdx, gprWrData});
      if (memReqValid && memReqReady) gotR.push_back({memReqAddr, memReqWrite, memReqByte,
        memReqWrite ? memReqData : 32'h0});
      if (!memRspReady) sawFull = 1'h1;
    end
  end
  function automatic logic [7:0] mb(input logic [31:0] a);
    return a[7:0] ^ a[15:8];
  endfunction
  function automatic logic [31:0] mw(input logic [31:0] a);
    return {mb(a), mb(a + 32'h1), mb(a + 32'h2), mb(a + 32'h3)};
  endfunction
  // Expected requests, writes and exception flags of one command.
  task automatic plan(input msms_row_type r);
    logic [31:0] ea, a, v, lastB;
    logic [4:0] ri;
    int n;
    expW.delete();
    expR.delete();
    expD = 1'h0;
    v = 32'h0;
    ea = r.bf != 5'h0 ? r.bv : 32'h0;
    if (!r.op[1]) begin
      ea = ea + {{16{r.off[15]}}, r.off[15:0]};
      n = 32 - int'(r.rd);
      lastB = ea + 32'(4 * n - 1);
      expA = ea[1:0] != 2'h0 && ea[31:12] != lastB[31:12];
      for (int k = 0; k < n && !expA && !expD; k++) begin
        a = ea + 32'(4 * k);
        ri = r.rd + 5'(k);
        expR.push_back({a, r.op == OP_STORE_MULTIPLE, 1'h0,
          r.op == OP_STORE_MULTIPLE ? {27'h3a5c0de, ri} : 32'h0});
        expD = a[31:12] == faultPage;
        if (!expD && r.op == OP_LOAD_MULTIPLE && (r.bf == 5'h0 || ri != r.bf)) begin
          expW.push_back({ri, mw(a)});
        end
      end
    end else begin
      expA = 1'h0;
      if (r.op == OP_LOAD_STRING_IDX) ea = ea + r.off;
      n = (r.op == OP_LOAD_STRING_IMM && r.n == 7'h0) ? 32 : int'(r.n);
      for (int k = 0; k < n; k++) begin
        a = ea + 32'(k);
        v[31 - 8 * (k % 4) -: 8] = mb(a);
        expR.push_back({a, 1'h0, 1'h1, 32'h0});
        if (k % 4 == 3 || k == n - 1) begin
          ri = r.rd + 5'(k / 4);
          if (r.bf == 5'h0 || ri != r.bf) expW.push_back({ri, v});
          v = 32'h0;
        end
      end
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk_idle();
    `CHK({cmdReady, memRspReady}, 2'h3)
    `CHK({memReqValid, gprWrValid, doneValid}, 3'h0)
  endtask
  // Issues one command, waits for its end and compares everything logged.
  task automatic run(input msms_row_type r);
    int t;
    plan(r);
    @(negedge clk_sys);
    gotW.delete();
    gotR.delete();
    sawFull = 1'h0;
    base = cyc;
    slowMem = r.mode == 1;
    stallMode = r.mode;
    cmdOp = r.op;
    cmdRegIdx = r.rd;
    cmdBaseField = r.bf;
    cmdBaseValue = r.bv;
    cmdIndexValue = r.off;
    cmdDisp = r.off[15:0];
    cmdImmByteCount = r.n[4:0];
    integerExceptionReg = {25'h0aaaaaa, r.n};
    cmdValid = 1'h1;
    @(negedge clk_sys);
    cmdValid = 1'h0;
    t = 1;
    while (doneValid !== 1'h1 && t < 3000) begin
      @(negedge clk_sys);
      t++;
    end
    if (t >= 3000) begin
      bad_count++;
      report_and_stop();
    end
    `CHK({doneDataExc, doneAlignExc}, {expD, expA})
    if (expA || (r.op == OP_LOAD_STRING_IDX && r.n == 7'h0)) `CHK(t, 1)
    if (r.mode == 2) `CHK(sawFull, 1'h1)
    repeat (2) @(negedge clk_sys);
    `CHK(gotW.size(), expW.size())
    foreach (expW[i]) if (i < gotW.size()) `CHK(gotW[i], expW[i])
    `CHK(gotR.size(), expR.size())
    foreach (expR[i]) if (i < gotR.size()) `CHK(gotR[i], expR[i])
    $display("test done: op %0d first register %0d", r.op, r.rd);
  endtask
  // Reset, table rows, a mid-run reset, a page fault and a misaligned cross.
  initial begin
    repeat (6) @(negedge clk_sys);
    chk_idle();
    rst = 1'h0;
    foreach (rows[i]) run(rows[i]);
    cmdRegIdx = 5'h0;
    cmdOp = OP_LOAD_MULTIPLE;
    cmdBaseField = 5'h0;
    cmdDisp = 16'h0800;
    cmdValid = 1'h1;
    @(negedge clk_sys);
    cmdValid = 1'h0;
    repeat (8) @(negedge clk_sys);
    rst = 1'h1;
    @(negedge clk_sys);
    chk_idle();
    rst = 1'h0;
    $display("test done: reset in mid-run");
    faultPage = 20'h00001;
    run('{OP_LOAD_MULTIPLE, 5'h1c, 5'h01, 32'hff8, 32'h0, 7'h0, 1});
    run('{OP_LOAD_MULTIPLE, 5'h1e, 5'h01, 32'hffe, 32'h0, 7'h0, 0});
    report_and_stop();
  end
endmodule
bind msms_sequencer msms_sequencer_chk chk (.*);
